// [src/slc_pkg.sv]
package slc_pkg;

	// ----------------------------------------------------------------
	// Link settings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PR_MAKER232, PR_FIELDBUS, PR_RTU, PR_ASCII} slc_proto_t;
	typedef enum logic [2:0] {BD_9600, BD_19200, BD_38400, BD_56000, BD_57600, BD_115200,
		BD_187500, BD_400000} slc_baud_t;
	typedef enum logic [1:0] {PA_NONE, PA_EVEN, PA_ODD} slc_parity_t;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SLC_CLK_HZ = 100_000_000;
	localparam int SLC_CLK_NS = 10;
	localparam int SLC_START_NS = 20_000_000;
	localparam int SLC_START_CYC = SLC_START_NS / SLC_CLK_NS;
	localparam logic [15:0] SLC_DIV_RESET = 16'(SLC_CLK_HZ / 38400);

	// ----------------------------------------------------------------
	// Address limits, defaults and character layout
	// ----------------------------------------------------------------
	localparam logic [7:0] SLC_ADDR_MIN_MAKER = 8'h03;
	localparam logic [7:0] SLC_ADDR_MAX_MAKER = 8'h7d;
	localparam logic [7:0] SLC_ADDR_MIN_MB = 8'h01;
	localparam logic [7:0] SLC_ADDR_MAX_MB = 8'hf7;
	localparam logic [7:0] SLC_ADDR_MAX_MULTI = 8'h63;
	localparam logic [7:0] SLC_ADDR_DEF_MAKER = 8'h03;
	localparam logic [7:0] SLC_ADDR_DEF_MB = 8'h01;
	localparam logic [3:0] SLC_START_BITS = 4'h1;
	localparam logic [3:0] SLC_DATA_BITS = 4'h8;
	localparam logic [3:0] SLC_STOP_BITS = 4'h1;

	// Clock cycles per bit for each rate.
	function automatic logic [15:0] slc_div(input slc_baud_t b);
		case (b)
			BD_9600: slc_div = 16'(SLC_CLK_HZ / 9600);
			BD_19200: slc_div = 16'(SLC_CLK_HZ / 19200);
			BD_38400: slc_div = 16'(SLC_CLK_HZ / 38400);
			BD_56000: slc_div = 16'(SLC_CLK_HZ / 56000);
			BD_57600: slc_div = 16'(SLC_CLK_HZ / 57600);
			BD_115200: slc_div = 16'(SLC_CLK_HZ / 115200);
			BD_187500: slc_div = 16'(SLC_CLK_HZ / 187500);
			default: slc_div = 16'(SLC_CLK_HZ / 400000);
		endcase
	endfunction : slc_div

	function automatic logic slc_addr_ok(input slc_proto_t p, input logic [7:0] a);
		if (p == PR_RTU || p == PR_ASCII) begin
			slc_addr_ok = a >= SLC_ADDR_MIN_MB && a <= SLC_ADDR_MAX_MB;
		end else begin
			slc_addr_ok = a >= SLC_ADDR_MIN_MAKER && a <= SLC_ADDR_MAX_MAKER;
		end
	endfunction : slc_addr_ok

	function automatic logic slc_baud_ok(input slc_proto_t p, input slc_baud_t b);
		case (p)
			PR_MAKER232: slc_baud_ok = b inside {BD_9600, BD_19200, BD_38400, BD_57600, BD_115200};
			PR_FIELDBUS: slc_baud_ok = b inside {BD_187500, BD_400000};
			default: slc_baud_ok = !(b inside {BD_187500, BD_400000});
		endcase
	endfunction : slc_baud_ok

	function automatic logic slc_is_mb(input slc_proto_t p);
		slc_is_mb = p == PR_RTU || p == PR_ASCII;
	endfunction : slc_is_mb

endpackage : slc_pkg

// [src/slc_startup_detect.sv]
`timescale 1ns/1ps
module slc_startup_detect
	import slc_pkg::*;
#(
	parameter int START_CYCLES = SLC_START_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic push_switch,
	output logic boot_load,
	output logic press_seen
);

	typedef enum logic [1:0] {ST_BOOT, ST_WAIT, ST_DONE} slc_sd_state_t;

	slc_sd_state_t state;
	logic [31:0] cnt;
	logic held;
	wire win_end = state == ST_WAIT && cnt == 32'(START_CYCLES - 1);

	// ----------------------------------------------------------------
	// Start-up window: the switch must stay pressed for all of it.
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_BOOT;
			cnt <= '0;
			held <= 1'b0;
			boot_load <= 1'b0;
			press_seen <= 1'b0;
		end else begin
			boot_load <= state == ST_BOOT;
			press_seen <= win_end && held && push_switch;
			case (state)
				ST_BOOT: begin
					state <= ST_WAIT;
					held <= push_switch;
				end
				ST_WAIT: begin
					cnt <= cnt + 32'h1;
					held <= held && push_switch;
					if (win_end) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: state <= ST_DONE;
				default: state <= ST_BOOT;
			endcase
		end
	end

	press_detect_a: assert property (@(posedge clk) disable iff (!reset_n)
		win_end && held && push_switch |=> press_seen) else $error("start-up press missed");
	press_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
		press_seen |-> $past(win_end)) else $error("press outside start-up window");

endmodule : slc_startup_detect

// [src/slc_config_selector.sv]
`timescale 1ns/1ps
module slc_config_selector
	import slc_pkg::*;
#(
	parameter int START_CYCLES = SLC_START_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic multi_channel,
	input wire logic push_switch,
	input wire logic mode_stored,
	input wire logic cfg_wr,
	input wire logic cfg_defaults,
	input wire slc_proto_t cfg_proto,
	input wire slc_baud_t cfg_baud,
	input wire logic [7:0] cfg_addr,
	input wire slc_parity_t cfg_parity,
	input wire logic sw_set,
	input wire slc_baud_t sw_baud,
	input wire logic [7:0] sw_addr,
	input wire logic rot_rs485,
	input wire logic [1:0] rot_baud,
	input wire logic [7:0] rot_addr,
	input wire logic rx_valid,
	input wire logic rx_rs485,
	input wire logic [7:0] rx_addr,
	input wire logic tx_req,
	output logic config_mode,
	output logic link_rs485,
	output slc_proto_t link_proto,
	output slc_baud_t link_baud,
	output logic [15:0] baud_div,
	output logic [7:0] node_addr,
	output slc_parity_t link_parity,
	output logic [3:0] frame_bits,
	output logic rx_accept,
	output logic tx_grant,
	output logic cfg_err
);

	// ----------------------------------------------------------------
	// Stored configuration and start-up detection
	// ----------------------------------------------------------------
	slc_proto_t st_proto;
	slc_baud_t st_baud;
	logic [7:0] st_addr;
	slc_parity_t st_parity;
	logic pend;
	logic boot_load;
	logic press_seen;

	slc_startup_detect #(
		.START_CYCLES(START_CYCLES)
	) u_detect (
		.clk(clk),
		.reset_n(reset_n),
		.push_switch(push_switch),
		.boot_load(boot_load),
		.press_seen(press_seen)
	);

	// ----------------------------------------------------------------
	// Write acceptance
	// ----------------------------------------------------------------
	wire is_mb_w = slc_is_mb(cfg_proto);
	wire par_ok = is_mb_w ? cfg_parity != 2'h3 : cfg_parity == PA_NONE;
	wire cfg_ok = cfg_wr && config_mode && !multi_channel
		&& (cfg_defaults || (slc_baud_ok(cfg_proto, cfg_baud)
		&& slc_addr_ok(cfg_proto, cfg_addr) && par_ok));
	wire sw_ok = sw_set && !multi_channel && !cfg_wr
		&& slc_baud_ok(st_proto, sw_baud) && slc_addr_ok(st_proto, sw_addr);
	wire next_err = (cfg_wr && !cfg_ok) || (sw_set && !sw_ok);

	// Factory defaults of the written protocol.
	wire slc_baud_t def_baud = cfg_proto == PR_MAKER232 ? BD_38400
		: cfg_proto == PR_FIELDBUS ? BD_187500 : BD_19200;
	wire [7:0] def_addr = is_mb_w ? SLC_ADDR_DEF_MB : SLC_ADDR_DEF_MAKER;
	wire slc_parity_t def_par = is_mb_w ? PA_EVEN : PA_NONE;

	// ----------------------------------------------------------------
	// Rotary switch decode for multi-channel units
	// ----------------------------------------------------------------
	wire slc_proto_t rot_proto = rot_rs485 ? PR_RTU : PR_MAKER232;
	wire slc_baud_t rot_b = rot_rs485
		? (rot_baud == 2'h0 ? BD_9600 : rot_baud == 2'h2 ? BD_38400 : BD_19200)
		: (rot_baud == 2'h1 ? BD_115200 : BD_38400);
	wire rot_a_ok = rot_addr <= SLC_ADDR_MAX_MULTI && slc_addr_ok(rot_proto, rot_addr);
	wire [7:0] rot_a = rot_a_ok ? rot_addr
		: (rot_rs485 ? SLC_ADDR_DEF_MB : SLC_ADDR_DEF_MAKER);

	// ----------------------------------------------------------------
	// Effective link settings
	// ----------------------------------------------------------------
	wire slc_proto_t next_proto = multi_channel ? rot_proto
		: config_mode ? PR_MAKER232 : st_proto;
	wire slc_baud_t next_baud = multi_channel ? rot_b
		: config_mode ? BD_38400 : st_baud;
	wire [7:0] next_addr = multi_channel ? rot_a
		: config_mode ? SLC_ADDR_DEF_MAKER : st_addr;
	wire slc_parity_t next_par = multi_channel ? (rot_rs485 ? PA_EVEN : PA_NONE)
		: config_mode ? PA_NONE : st_parity;
	wire [3:0] next_bits = SLC_START_BITS + SLC_DATA_BITS + SLC_STOP_BITS
		+ {3'h0, next_par != PA_NONE};

	// ----------------------------------------------------------------
	// Frame filter and reply permission
	// ----------------------------------------------------------------
	wire accept_now = rx_valid && rx_rs485 == link_rs485 && rx_addr == node_addr;
	wire grant_now = tx_req && pend;
	wire next_pend = accept_now || (pend && !grant_now);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_proto <= PR_MAKER232;
			st_baud <= BD_38400;
			st_addr <= SLC_ADDR_DEF_MAKER;
			st_parity <= PA_NONE;
		end else if (cfg_ok) begin
			st_proto <= cfg_proto;
			st_baud <= cfg_defaults ? def_baud : cfg_baud;
			st_addr <= cfg_defaults ? def_addr : cfg_addr;
			st_parity <= cfg_defaults ? def_par : cfg_parity;
		end else if (sw_ok) begin
			st_baud <= sw_baud;
			st_addr <= sw_addr;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			config_mode <= 1'b0;
			pend <= 1'b0;
			rx_accept <= 1'b0;
			tx_grant <= 1'b0;
			cfg_err <= 1'b0;
		end else begin
			if (boot_load) begin
				config_mode <= mode_stored;
			end else if (press_seen) begin
				config_mode <= !config_mode;
			end
			pend <= next_pend;
			rx_accept <= accept_now;
			tx_grant <= grant_now;
			cfg_err <= next_err;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link_proto <= PR_MAKER232;
			link_rs485 <= 1'b0;
			link_baud <= BD_38400;
			baud_div <= SLC_DIV_RESET;
			node_addr <= SLC_ADDR_DEF_MAKER;
			link_parity <= PA_NONE;
			frame_bits <= SLC_START_BITS + SLC_DATA_BITS + SLC_STOP_BITS;
		end else begin
			link_proto <= next_proto;
			link_rs485 <= next_proto != PR_MAKER232;
			link_baud <= next_baud;
			baud_div <= slc_div(next_baud);
			node_addr <= next_addr;
			link_parity <= next_par;
			frame_bits <= next_bits;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	cfg_force_a: assert property (config_mode && !multi_channel |=> link_proto == PR_MAKER232
		&& link_baud == BD_38400 && !link_rs485) else $error("config mode not forced");
	single_baud_a: assert property (!multi_channel && link_proto == PR_MAKER232 |-> link_baud
		inside {BD_9600, BD_19200, BD_38400, BD_57600, BD_115200}) else $error("bad RS232 rate");
	multi_baud_a: assert property (multi_channel && !rot_rs485 |=> link_baud
		inside {BD_38400, BD_115200}) else $error("bad multi-channel rate");
	slave_only_a: assert property (tx_grant |-> $past(pend) && $past(tx_req))
		else $error("transmit without request");
	rs485_deaf_a: assert property (rx_valid && rx_rs485 != link_rs485 |=> !rx_accept)
		else $error("frame on wrong medium taken");
	addr_filter_a: assert property (rx_valid && rx_addr != node_addr |=> !rx_accept)
		else $error("foreign address taken");
	match_take_a: assert property (rx_valid && rx_rs485 == link_rs485 && rx_addr == node_addr
		|=> rx_accept ##1 tx_grant == $past(tx_req)) else $error("frame or reply lost");
	mode_toggle_a: assert property (press_seen && !boot_load |=> config_mode != $past(config_mode))
		else $error("switch did not toggle mode");
	wr_lock_a: assert property (cfg_wr && !config_mode |=> cfg_err && $stable(st_proto))
		else $error("write outside config mode");
	addr_range_a: assert property (!multi_channel && !slc_is_mb(link_proto) |-> node_addr
		>= SLC_ADDR_MIN_MAKER && node_addr <= SLC_ADDR_MAX_MAKER) else $error("address out of range");
	rtu_default_a: assert property (cfg_ok && cfg_defaults && cfg_proto == PR_RTU |=> st_baud
		== BD_19200 && st_parity == PA_EVEN && st_addr == SLC_ADDR_DEF_MB) else $error("bad defaults");
	frame_len_a: assert property (frame_bits == (link_parity == PA_NONE ? 4'ha : 4'hb))
		else $error("bad character length");
	multi_par_a: assert property (multi_channel && rot_rs485 |=> link_proto == PR_RTU
		&& link_parity == PA_EVEN && link_rs485) else $error("multi-channel Modbus not even");

	enter_cfg_c: cover property (press_seen ##1 config_mode);
	reply_c: cover property (rx_accept ##[1:20] tx_grant);
	sw_change_c: cover property (sw_ok ##1 !config_mode);
	wr_reject_c: cover property (cfg_wr && config_mode && !cfg_ok);

endmodule : slc_config_selector

// [dv/slc_master_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus master model
// ----------------------------------------------------------------
module slc_master_model (
	input wire logic clk,
	output logic rx_valid,
	output logic rx_rs485,
	output logic [7:0] rx_addr,
	output logic tx_req
);
	initial begin
		rx_valid = 1'b0;
		rx_rs485 = 1'b0;
		rx_addr = 8'h00;
		tx_req = 1'b0;
	end

	// A request is addressed to one slave only, on the medium given by rs485.
	task send_frame(input logic rs485, input logic [7:0] addr);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_rs485 = rs485;
		rx_addr = addr;
		@(negedge clk);
		rx_valid = 1'b0;
		rx_rs485 = ~rs485;
		rx_addr = ~addr;
	endtask : send_frame

	task ask_reply();
		@(negedge clk);
		tx_req = 1'b1;
		@(negedge clk);
		tx_req = 1'b0;
	endtask : ask_reply
endmodule : slc_master_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import slc_pkg::*;
	localparam int START = 16;
	logic clk, reset_n, multi_channel, push_switch, mode_stored, cfg_wr, cfg_defaults;
	logic sw_set, rot_rs485, rx_valid, rx_rs485, tx_req, config_mode, link_rs485;
	logic rx_accept, tx_grant, cfg_err;
	slc_proto_t cfg_proto, link_proto;
	slc_baud_t cfg_baud, sw_baud, link_baud;
	slc_parity_t cfg_parity, link_parity;
	logic [1:0] rot_baud;
	logic [7:0] cfg_addr, sw_addr, rot_addr, rx_addr, node_addr;
	logic [15:0] baud_div;
	logic [3:0] frame_bits;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;

	slc_config_selector #(.START_CYCLES(START)) slc_config_selector_i (.clk(clk),
		.reset_n(reset_n), .multi_channel(multi_channel), .push_switch(push_switch),
		.mode_stored(mode_stored), .cfg_wr(cfg_wr), .cfg_defaults(cfg_defaults),
		.cfg_proto(cfg_proto), .cfg_baud(cfg_baud), .cfg_addr(cfg_addr),
		.cfg_parity(cfg_parity), .sw_set(sw_set), .sw_baud(sw_baud), .sw_addr(sw_addr),
		.rot_rs485(rot_rs485), .rot_baud(rot_baud), .rot_addr(rot_addr),
		.rx_valid(rx_valid), .rx_rs485(rx_rs485), .rx_addr(rx_addr), .tx_req(tx_req),
		.config_mode(config_mode), .link_rs485(link_rs485), .link_proto(link_proto),
		.link_baud(link_baud), .baud_div(baud_div), .node_addr(node_addr),
		.link_parity(link_parity), .frame_bits(frame_bits), .rx_accept(rx_accept),
		.tx_grant(tx_grant), .cfg_err(cfg_err));

	slc_master_model slc_master_model_i (.clk(clk), .rx_valid(rx_valid),
		.rx_rs485(rx_rs485), .rx_addr(rx_addr), .tx_req(tx_req));

	// ----------------------------------------------------------------
	// Clock, watchdog and helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			final_report();
		end
	end

	task final_report();
		if (err_total == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	task check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_val

	// Looks for rx_accept (0), tx_grant (1) or cfg_err (2) high now or at either of the next two falling edges.
	task check_pulse(input int sel, input logic exp, input string what);
		logic seen;
		seen = 1'b0;
		repeat (3) begin
			if ((sel == 0 ? rx_accept : sel == 1 ? tx_grant : cfg_err) === 1'b1) begin
				seen = 1'b1;
			end
			@(negedge clk);
		end
		check_val({15'h0000, seen}, {15'h0000, exp}, what);
	endtask : check_pulse

	task put(input logic sw, input slc_proto_t p, input slc_baud_t b, input logic [7:0] a,
		input slc_parity_t par, input logic err);
		@(negedge clk);
		if (sw) begin
			sw_set = 1'b1;
			sw_baud = b;
			sw_addr = a;
		end else begin
			cfg_wr = 1'b1;
			cfg_proto = p;
			cfg_baud = b;
			cfg_addr = a;
			cfg_parity = par;
		end
		@(negedge clk);
		sw_set = 1'b0;
		cfg_wr = 1'b0;
		check_pulse(2, err, "refusal");
	endtask : put

	task check_link(input logic rs, input slc_proto_t p, input slc_baud_t b,
		input logic [7:0] a, input slc_parity_t par, input logic [3:0] fb);
		check_val({15'h0000, link_rs485}, {15'h0000, rs}, "medium");
		check_val(16'(link_proto), 16'(p), "protocol");
		check_val(16'(link_baud), 16'(b), "rate");
		check_val({8'h00, node_addr}, {8'h00, a}, "node");
		check_val(16'(link_parity), 16'(par), "parity");
		check_val({12'h000, frame_bits}, {12'h000, fb}, "frame bits");
	endtask : check_link

	task do_reset(input logic push);
		push_switch = push;
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		repeat (START + 6) @(negedge clk);
		push_switch = 1'b0;
	endtask : do_reset

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_defaults();
		check_val({15'h0000, config_mode}, 16'h0000, "mode");
		check_link(1'b0, PR_MAKER232, BD_38400, 8'h03, PA_NONE, 4'ha);
		check_val(baud_div, 16'h0a2c, "divider");
	endtask : t_defaults

	task t_switch();
		put(1'b1, PR_MAKER232, BD_9600, 8'h7d, PA_NONE, 1'b0);
		check_link(1'b0, PR_MAKER232, BD_9600, 8'h7d, PA_NONE, 4'ha);
		check_val(baud_div, 16'h28b0, "divider");
		put(1'b1, PR_MAKER232, BD_187500, 8'h10, PA_NONE, 1'b1);
		put(1'b1, PR_MAKER232, BD_19200, 8'h7e, PA_NONE, 1'b1);
		put(1'b0, PR_RTU, BD_19200, 8'h01, PA_EVEN, 1'b1);
		check_link(1'b0, PR_MAKER232, BD_9600, 8'h7d, PA_NONE, 4'ha);
	endtask : t_switch

	task t_frames();
		slc_master_model_i.send_frame(1'b0, 8'h7d);
		check_pulse(0, 1'b1, "accept");
		slc_master_model_i.ask_reply();
		check_pulse(1, 1'b1, "grant");
		slc_master_model_i.ask_reply();
		check_pulse(1, 1'b0, "unasked grant");
		slc_master_model_i.send_frame(1'b0, 8'h04);
		check_pulse(0, 1'b0, "foreign frame");
	endtask : t_frames

	task t_config();
		do_reset(1'b1);
		check_val({15'h0000, config_mode}, 16'h0001, "mode");
		put(1'b0, PR_RTU, BD_115200, 8'hf7, PA_ODD, 1'b0);
		put(1'b0, PR_ASCII, BD_57600, 8'h80, PA_NONE, 1'b0);
		check_val(16'(slc_config_selector_i.st_proto), 16'(PR_ASCII), "stored protocol");
		put(1'b0, PR_FIELDBUS, BD_400000, 8'h7d, PA_NONE, 1'b0);
		check_val(16'(slc_config_selector_i.st_baud), 16'(BD_400000), "stored rate");
		put(1'b0, PR_RTU, BD_56000, 8'h00, PA_EVEN, 1'b1);
		put(1'b0, PR_FIELDBUS, BD_9600, 8'h03, PA_NONE, 1'b1);
		put(1'b0, PR_MAKER232, BD_38400, 8'h03, PA_EVEN, 1'b1);
		cfg_defaults = 1'b1;
		put(1'b0, PR_FIELDBUS, BD_9600, 8'h00, PA_ODD, 1'b0);
		check_val(16'(slc_config_selector_i.st_baud), 16'(BD_187500), "default rate");
		put(1'b0, PR_RTU, BD_9600, 8'h00, PA_ODD, 1'b0);
		check_val(16'(slc_config_selector_i.st_parity), 16'(PA_EVEN), "default parity");
		check_val({8'h00, slc_config_selector_i.st_addr}, 16'h0001, "default node");
		cfg_defaults = 1'b0;
		check_link(1'b0, PR_MAKER232, BD_38400, 8'h03, PA_NONE, 4'ha);
		mode_stored = 1'b1;
		do_reset(1'b1);
		check_val({15'h0000, config_mode}, 16'h0000, "mode");
	endtask : t_config

	task t_multi();
		multi_channel = 1'b1;
		rot_rs485 = 1'b1;
		rot_baud = 2'h0;
		rot_addr = 8'h05;
		repeat (3) @(negedge clk);
		check_link(1'b1, PR_RTU, BD_9600, 8'h05, PA_EVEN, 4'hb);
		slc_master_model_i.send_frame(1'b0, 8'h05);
		check_pulse(0, 1'b0, "wrong medium");
		slc_master_model_i.send_frame(1'b1, 8'h05);
		check_pulse(0, 1'b1, "accept");
		rot_rs485 = 1'b0;
		rot_baud = 2'h1;
		rot_addr = 8'h63;
		repeat (3) @(negedge clk);
		check_link(1'b0, PR_MAKER232, BD_115200, 8'h63, PA_NONE, 4'ha);
		rot_baud = 2'h2;
		repeat (3) @(negedge clk);
		check_val(16'(link_baud), 16'(BD_38400), "rate");
		rot_rs485 = 1'b1;
		rot_baud = 2'h1;
		rot_addr = 8'h00;
		repeat (3) @(negedge clk);
		check_link(1'b1, PR_RTU, BD_19200, 8'h01, PA_EVEN, 4'hb);
		put(1'b0, PR_RTU, BD_19200, 8'h01, PA_EVEN, 1'b1);
		put(1'b1, PR_MAKER232, BD_9600, 8'h05, PA_NONE, 1'b1);
	endtask : t_multi

	initial begin
		{multi_channel, push_switch, mode_stored, cfg_wr, cfg_defaults, sw_set} = 6'h00;
		{rot_rs485, rot_baud, rot_addr, cfg_addr, sw_addr} = 27'h0000000;
		cfg_proto = PR_MAKER232;
		cfg_baud = BD_38400;
		sw_baud = BD_38400;
		cfg_parity = PA_NONE;
		do_reset(1'b0);
		t_defaults();
		t_switch();
		t_frames();
		t_config();
		t_multi();
		final_report();
	end
endmodule : testbench
